//--- design/flash_ident_pkg.sv
// Package: constants and carrier types for the identifier space and status pin block
package flash_ident_pkg;

  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Command bytes and configuration codes
  localparam logic [7:0] CMD_PIN_CONFIG = 8'hB8;
  localparam logic [7:0] CODE_READY_BUSY = 8'h00;
  localparam logic [7:0] CODE_PULSE_ERASE = 8'h01;
  localparam logic [7:0] CODE_PULSE_PROG = 8'h02;
  localparam logic [7:0] CODE_PULSE_BOTH = 8'h03;

  // Pulse width and latency figures in their own units
  localparam int unsigned PULSE_LOW_NS = 250;
  localparam int unsigned PULSE_LOW_CYC = (PULSE_LOW_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned PROG_SUSPEND_MAX_US = 20;
  localparam int unsigned ERASE_SUSPEND_MAX_US = 25;
  localparam int unsigned SUSPEND_TYP_US = 1;
  localparam int unsigned PROG_SUSPEND_MAX_CYC = (PROG_SUSPEND_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned ERASE_SUSPEND_MAX_CYC = (ERASE_SUSPEND_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned SUSPEND_TYP_CYC = (SUSPEND_TYP_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned WORD_PROG_EFF_US = 12;
  localparam int unsigned BYTE_PROG_EFF_US = 6;
  localparam int unsigned WORD_PROG_EFF_CYC = (WORD_PROG_EFF_US * 1000000) / CLK_PERIOD_PS;

  // Identifier space word addresses
  localparam logic [20:0] ID_ADDR_MAKER = 21'h000000;
  localparam logic [20:0] ID_ADDR_PART = 21'h000001;
  localparam logic [15:0] ID_OFS_BLOCK_PROT = 16'h0002;
  localparam logic [20:0] ID_ADDR_BURST_CFG = 21'h000005;
  localparam logic [20:0] ID_ADDR_PROT_BASE = 21'h000080;
  localparam int unsigned PROT_SEL_BIT = 7;
  localparam logic [3:0] PROT_LOCK_IDX = 4'h0;
  localparam logic [3:0] PROT_UID_LAST = 4'h4;
  localparam logic [3:0] PROT_USER_LAST = 4'h8;
  localparam int unsigned PROT_WORDS = 9;
  localparam int unsigned BLOCK_BITS = 5;
  localparam int unsigned BLOCKS = 32;
  localparam logic [15:0] PROT_YES = 16'h0001;
  localparam logic [15:0] PROT_NO = 16'h0000;
  localparam logic [15:0] PROT_LOCK_RESET = 16'hFFFE;
  localparam logic [15:0] BURST_CFG_RESET = 16'hBFCF;

  typedef enum logic [3:0] {
    PIN_LEVEL = 4'b0001,
    PIN_ERASE = 4'b0010,
    PIN_PROG = 4'b0100,
    PIN_BOTH = 4'b1000
  } pin_mode_t;

  // Controller activity as seen by this block
  typedef struct packed {
    logic busy;
    logic suspended;
    logic erase_done;
    logic prog_done;
  } pe_status_t;

  // Bus write carried into the block
  typedef struct packed {
    logic valid;
    logic [20:0] addr;
    logic [15:0] data;
  } bus_wr_t;

endpackage

//--- design/flash_ident_status.sv
// Identifier read space, status pin configuration and suspend latency for a parallel flash
// Function
// [R1] Level mode: pin low while busy, else released
// [R2] Code 01h: pulse on erase completion only
// [R3] Code 02h: pulse on program completion only
// [R4] Code 03h: pulse on either completion
// [R5] Pulse holds low about 250 ns
// [R6] Addresses 0 and 1 give maker, part
// [R7] Block start plus 2 gives protection state
// [R8] Address 5 gives burst configuration value
// [R9] Protection words start at word 80h
// [R10] Lock, four unique, four user words
// [R11] Buffered programming: 12 us per word
// [R12] Program suspend pauses within 20 us
// [R13] Erase suspend pauses within 25 us
// [R14] Reset selects level ready/busy mode
// [R15] Configure refused while busy or suspended
// [R16] Invalid code flags a status error
// [R17] Host writes B8h then the code
`timescale 1ns/1ps
module flash_ident_status #(
  parameter logic [15:0] MAKER_ID = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h5A01, // Arbitrary value
  parameter int unsigned PROG_SUSPEND_CYC = flash_ident_pkg::PROG_SUSPEND_MAX_CYC,
  parameter int unsigned ERASE_SUSPEND_CYC = flash_ident_pkg::ERASE_SUSPEND_MAX_CYC,
  parameter int unsigned WORD_PROG_CYC = flash_ident_pkg::WORD_PROG_EFF_CYC
) (
  input wire logic ref_clk_i, // System clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire flash_ident_pkg::bus_wr_t cmd_wr_i, // Decoded bus write
  input wire logic [20:0] rd_addr_i, // Identifier read address
  input wire logic [31:0] block_prot_i, // Per-block protection flags
  input wire logic [15:0] burst_cfg_i, // Burst configuration value
  input wire logic [143:0] prot_words_i, // Stored protection words
  input wire logic prog_start_i, // Buffered program of N words starts
  input wire logic [4:0] prog_words_i, // Word count minus one of that program
  input wire logic erase_start_i, // Block erase starts
  input wire logic [31:0] erase_cycles_i, // Erase duration in cycles
  input wire logic suspend_i, // Suspend command pulse
  input wire logic resume_i, // Resume command pulse
  output logic [15:0] ident_data_o, // Identifier data, registered
  output logic sts_oe_o, // Ready-status pin pulled low when high
  output logic sts_out_o, // Ready-status pin value, always low
  output logic busy_o, // Controller busy
  output logic suspended_o, // Operation suspended
  output logic cfg_error_o, // Invalid code seen, sticky
  output logic [3:0] pin_mode_o // Current pin mode
);

  // ------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_IDLE = 4'b0001,
    OP_PROG = 4'b0010,
    OP_ERASE = 4'b0100,
    OP_PAUSE = 4'b1000
  } op_state_t;

  op_state_t op_state;
  op_state_t paused_from;
  logic [31:0] op_count;
  logic [31:0] pause_count;
  logic pause_req;
  logic cfg_armed;
  logic busy_now;
  flash_ident_pkg::pin_mode_t pin_mode;
  flash_ident_pkg::pe_status_t pe;
  logic [15:0] ident_comb;
  logic sts_oe;
  logic cfg_second;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic code_valid(input logic [15:0] d);
    code_valid = d[15:8] == 8'h00 && d[7:0] <= flash_ident_pkg::CODE_PULSE_BOTH;
  endfunction

  function automatic flash_ident_pkg::pin_mode_t code_to_mode(input logic [7:0] c);
    unique case (c)
      flash_ident_pkg::CODE_PULSE_ERASE: code_to_mode = flash_ident_pkg::PIN_ERASE;
      flash_ident_pkg::CODE_PULSE_PROG: code_to_mode = flash_ident_pkg::PIN_PROG;
      flash_ident_pkg::CODE_PULSE_BOTH: code_to_mode = flash_ident_pkg::PIN_BOTH;
      default: code_to_mode = flash_ident_pkg::PIN_LEVEL;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Program/erase timing model
  // ------------------------------------------------------------
  assign busy_now = op_state == OP_PROG || op_state == OP_ERASE;

  // Duration per buffered word is the effective time, not the raw cell time
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_state <= OP_IDLE;
      paused_from <= OP_IDLE;
      op_count <= 32'h0000_0000;
      pe.erase_done <= 1'b0;
      pe.prog_done <= 1'b0;
    end else begin
      pe.erase_done <= 1'b0;
      pe.prog_done <= 1'b0;
      unique case (op_state)
        OP_IDLE: begin
          if (prog_start_i) begin
            op_state <= OP_PROG;
            op_count <= 32'(WORD_PROG_CYC) * (32'(prog_words_i) + 32'h0000_0001); // see [R11]
          end else if (erase_start_i) begin
            op_state <= OP_ERASE;
            op_count <= erase_cycles_i;
          end
        end
        OP_PROG, OP_ERASE: begin
          if (pause_req && pause_count == 32'h0000_0000) begin
            paused_from <= op_state;
            op_state <= OP_PAUSE;
          end else if (op_count <= 32'h0000_0001) begin
            op_state <= OP_IDLE;
            pe.prog_done <= op_state == OP_PROG;
            pe.erase_done <= op_state == OP_ERASE;
          end else begin
            op_count <= op_count - 32'h0000_0001;
          end
        end
        OP_PAUSE: begin
          if (resume_i) begin
            op_state <= paused_from;
          end
        end
      endcase
    end
  end

  // Pause takes the typical latency, clamped to the worst case limit
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pause_req <= 1'b0;
      pause_count <= 32'h0000_0000;
    end else if (suspend_i && busy_now && !pause_req) begin
      pause_req <= 1'b1;
      if (op_state == OP_PROG) begin
        pause_count <= 32'(flash_ident_pkg::SUSPEND_TYP_CYC < PROG_SUSPEND_CYC ?
                           flash_ident_pkg::SUSPEND_TYP_CYC : PROG_SUSPEND_CYC); // see [R12]
      end else begin
        pause_count <= 32'(flash_ident_pkg::SUSPEND_TYP_CYC < ERASE_SUSPEND_CYC ?
                           flash_ident_pkg::SUSPEND_TYP_CYC : ERASE_SUSPEND_CYC); // see [R13]
      end
    end else if (!busy_now) begin
      pause_req <= 1'b0;
    end else if (pause_req && pause_count != 32'h0000_0000) begin
      pause_count <= pause_count - 32'h0000_0001;
    end
  end

  always_comb begin
    pe.busy = busy_now;
    pe.suspended = op_state == OP_PAUSE;
  end

  // ------------------------------------------------------------
  // Status pin configuration command
  // ------------------------------------------------------------
  assign cfg_second = cmd_wr_i.valid && cfg_armed;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_armed <= 1'b0;
    end else if (cmd_wr_i.valid) begin
      // Refused setup leaves nothing armed; second write always disarms
      cfg_armed <= !cfg_armed && cmd_wr_i.data[7:0] == flash_ident_pkg::CMD_PIN_CONFIG
                   && !busy_now && op_state != OP_PAUSE; // see [R15] see [R17]
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_mode <= flash_ident_pkg::PIN_LEVEL; // see [R14]
    end else if (cfg_second && code_valid(cmd_wr_i.data)) begin
      pin_mode <= code_to_mode(cmd_wr_i.data[7:0]);
    end
  end

  // Sticky until reset; clearing belongs to the status register owner
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_error_o <= 1'b0;
    end else if (cfg_second && !code_valid(cmd_wr_i.data)) begin
      cfg_error_o <= 1'b1; // see [R16]
    end
  end

  // ------------------------------------------------------------
  // Pin driver and identifier decode
  // ------------------------------------------------------------
  sts_pulse_gen u_pulse (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(pin_mode),
    .pe_i(pe),
    .pin_oe_o(sts_oe)
  );

  ident_decode u_decode (
    .addr_i(rd_addr_i),
    .maker_id_i(MAKER_ID),
    .part_id_i(PART_ID),
    .block_prot_i(block_prot_i),
    .burst_cfg_i(burst_cfg_i),
    .prot_words_i(prot_words_i),
    .data_o(ident_comb)
  );

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ident_data_o <= 16'h0000;
      busy_o <= 1'b0;
      suspended_o <= 1'b0;
      pin_mode_o <= flash_ident_pkg::PIN_LEVEL;
      sts_out_o <= 1'b0;
    end else begin
      ident_data_o <= ident_comb; // see [R6]
      busy_o <= pe.busy;
      suspended_o <= pe.suspended;
      pin_mode_o <= pin_mode;
      sts_out_o <= 1'b0;
    end
  end

  assign sts_oe_o = sts_oe;

endmodule

//--- design/ident_decode.sv
// Identifier space read decoder
`timescale 1ns/1ps
module ident_decode (
  input wire logic [20:0] addr_i, // Word address
  input wire logic [15:0] maker_id_i, // Maker identifier
  input wire logic [15:0] part_id_i, // Part identifier
  input wire logic [31:0] block_prot_i, // Per-block protection
  input wire logic [15:0] burst_cfg_i, // Burst configuration value
  input wire logic [143:0] prot_words_i, // Protection words, lock first
  output logic [15:0] data_o // Identifier data
);

  logic [15:0] low_ofs;
  logic [3:0] idx;

  assign low_ofs = addr_i[15:0];
  assign idx = addr_i[3:0];

  always_comb begin
    data_o = 16'h0000;
    if (addr_i == flash_ident_pkg::ID_ADDR_MAKER) begin
      data_o = maker_id_i; // see [R6]
    end else if (addr_i == flash_ident_pkg::ID_ADDR_PART) begin
      data_o = part_id_i; // see [R6]
    end else if (addr_i == flash_ident_pkg::ID_ADDR_BURST_CFG) begin
      data_o = burst_cfg_i; // see [R8]
    end else if (addr_i[20:4] == flash_ident_pkg::ID_ADDR_PROT_BASE[20:4]
                 && idx <= flash_ident_pkg::PROT_USER_LAST) begin
      // Upper offset bits must be clear too, or 90h..F8h would alias the words
      data_o = prot_words_i[idx * 16 +: 16]; // see [R9] see [R10]
    end else if (low_ofs == flash_ident_pkg::ID_OFS_BLOCK_PROT) begin
      data_o = block_prot_i[addr_i[20:16]] ? flash_ident_pkg::PROT_YES
                                           : flash_ident_pkg::PROT_NO; // see [R7]
    end
  end

endmodule

//--- design/sts_pulse_gen.sv
// Ready-status pin driver: level mode or timed low pulses
`timescale 1ns/1ps
module sts_pulse_gen (
  input wire logic ref_clk_i, // System clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire flash_ident_pkg::pin_mode_t mode_i, // Pin mode
  input wire flash_ident_pkg::pe_status_t pe_i, // Controller activity
  output logic pin_oe_o // High while pin is pulled low
);

  logic [7:0] count;
  logic fire;

  always_comb begin
    unique case (mode_i)
      flash_ident_pkg::PIN_ERASE: fire = pe_i.erase_done; // see [R2]
      flash_ident_pkg::PIN_PROG: fire = pe_i.prog_done; // see [R3]
      flash_ident_pkg::PIN_BOTH: fire = pe_i.erase_done | pe_i.prog_done; // see [R4]
      default: fire = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= 8'h00;
    end else if (fire) begin
      count <= 8'(flash_ident_pkg::PULSE_LOW_CYC); // see [R5]
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // Pin is open drain: output value is always low, enable decides
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_oe_o <= 1'b0;
    end else if (mode_i == flash_ident_pkg::PIN_LEVEL) begin
      pin_oe_o <= pe_i.busy; // see [R1]
    end else begin
      pin_oe_o <= fire | (count > 8'h01); // see [R5]
    end
  end

endmodule

//--- sim/flash_ident_status_assertions.sv
// Checker: port assertions for the identifier space and status pin block
`timescale 1ns/1ps
module flash_ident_status_assertions #(
  parameter logic [15:0] MAKER_ID = 16'h00A5 // Arbitrary value
) (
  input wire logic ref_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire flash_ident_pkg::bus_wr_t cmd_wr_i, // Bus write
  input wire logic [20:0] rd_addr_i, // Read address
  input wire logic [31:0] block_prot_i, // Block flags
  input wire logic [143:0] prot_words_i, // Protection words
  input wire logic prog_start_i, // Program start
  input wire logic erase_start_i, // Erase start
  input wire logic suspend_i, // Suspend pulse
  input wire logic [15:0] ident_data_o, // Identifier data
  input wire logic sts_oe_o, // Pin pulled low
  input wire logic busy_o, // Busy
  input wire logic suspended_o, // Suspended
  input wire logic cfg_error_o, // Config error
  input wire logic [3:0] pin_mode_o // Pin mode
);
  // ---
  // Helpers
  // ---
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [5:0] low_cnt;
  logic [1:0] code_d1, code_d2;
  logic last_erase, prot_q;
  logic [15:0] word_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= sts_oe_o ? low_cnt + 6'd1 : 6'd0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    code_d1 <= cmd_wr_i.data[1:0];
    code_d2 <= code_d1;
    prot_q <= block_prot_i[rd_addr_i[20:16]];
    word_q <= prot_words_i[16 * rd_addr_i[3:0] +: 16];
    if (!busy_o && (prog_start_i || erase_start_i)) begin
      last_erase <= !prog_start_i;
    end
  end
  sequence s_arm;
    cmd_wr_i.valid && cmd_wr_i.data[7:0] == 8'hB8 && !busy_o && !suspended_o ##1 cmd_wr_i.valid;
  endsequence
  a_maker_read: assert property (rd_addr_i == 21'h0 |=> ident_data_o == MAKER_ID)
    else $error("maker identifier wrong");
  a_prot_status: assert property (rd_addr_i[15:0] == 16'h2 |=> ident_data_o == {15'h0, prot_q})
    else $error("block protection word wrong");
  a_prot_word: assert property (rd_addr_i[20:7] == 14'h1 && rd_addr_i[6:0] <= 7'd8
    |=> ident_data_o == word_q) else $error("protection word wrong");
  a_level_busy: assert property ((pin_mode_o == 4'h1 && busy_o && !suspended_o) [*3] |-> sts_oe_o)
    else $error("pin not low while busy");
  a_pulse_width: assert property ($fell(sts_oe_o) && pin_mode_o != 4'h1
    |-> low_cnt == 6'(flash_ident_pkg::PULSE_LOW_CYC)) else $error("pulse width wrong");
  a_pulse_kind: assert property ($rose(sts_oe_o) && (pin_mode_o == 4'h2 || pin_mode_o == 4'h4)
    |-> last_erase == pin_mode_o[1]) else $error("pulse for wrong operation");
  a_reset_mode: assert property ($fell(sys_rst_i) |-> pin_mode_o == 4'h1)
    else $error("mode after reset wrong");
  a_cfg_apply: assert property (s_arm ##0 cmd_wr_i.data <= 16'h3 |-> ##2 pin_mode_o == 4'h1 << code_d2)
    else $error("configuration not applied");
  a_cfg_error: assert property (s_arm ##0 cmd_wr_i.data > 16'h3 |=> cfg_error_o)
    else $error("invalid code not flagged");
  a_cfg_refuse: assert property (cmd_wr_i.valid && cmd_wr_i.data[7:0] == 8'hB8 && (busy_o || suspended_o)
    |-> ##4 pin_mode_o == $past(pin_mode_o, 4)) else $error("configuration accepted while busy");
  a_suspend_bound: assert property (suspend_i && busy_o && !suspended_o
    |-> ##[1:8] (suspended_o || !busy_o)) else $error("suspend too slow");
  c_pulse_both: cover property ($rose(sts_oe_o) && pin_mode_o == 4'h8);
  c_suspended: cover property ($rose(suspended_o));
  c_cfg_error: cover property ($rose(cfg_error_o));
endmodule

bind flash_ident_status flash_ident_status_assertions #(.MAKER_ID(MAKER_ID)) u_chk (.ref_clk_i,
  .sys_rst_i, .cmd_wr_i, .rd_addr_i, .block_prot_i, .prot_words_i, .prog_start_i, .erase_start_i,
  .suspend_i, .ident_data_o, .sts_oe_o, .busy_o, .suspended_o, .cfg_error_o, .pin_mode_o);

//--- sim/flash_ident_status_tb_top.sv
// Testbench: random and corner stimulus with self checks for the identifier and status pin block
`timescale 1ns/1ps
module flash_ident_status_tb_top;
  localparam logic [15:0] MAKER = 16'h00A5; // Arbitrary value
  localparam logic [15:0] PART = 16'h5A01; // Arbitrary value
  localparam int WPC = 8;
  logic ref_clk_i = 0, sys_rst_i = 1, prog_go = 0, erase_go = 0, susp = 0, resm = 0;
  logic sts_oe, sts_q = 0, busy, susp_o, cerr;
  flash_ident_pkg::bus_wr_t cmd_wr;
  logic [20:0] rd_addr = '0, a;
  logic [31:0] bprot = '0, ecyc = 32'd40;
  logic [15:0] burst = '0, ident;
  logic [143:0] pwords = '0;
  logic [4:0] nwords = '0;
  logic [3:0] mode;
  int num_errors = 0, cmp_count = 0, seed = 68787, rises = 0, i, c, k, len;
  always #4 ref_clk_i = ~ref_clk_i;
  host_bus_model HOST (.ref_clk_i(ref_clk_i), .cmd_wr_o(cmd_wr));
  flash_ident_status #(.MAKER_ID(MAKER), .PART_ID(PART), .PROG_SUSPEND_CYC(4),
    .ERASE_SUSPEND_CYC(4), .WORD_PROG_CYC(WPC)) DUT (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .cmd_wr_i(cmd_wr), .rd_addr_i(rd_addr), .block_prot_i(bprot),
    .burst_cfg_i(burst), .prot_words_i(pwords), .prog_start_i(prog_go), .prog_words_i(nwords),
    .erase_start_i(erase_go), .erase_cycles_i(ecyc), .suspend_i(susp), .resume_i(resm),
    .ident_data_o(ident), .sts_oe_o(sts_oe), .sts_out_o(), .busy_o(busy),
    .suspended_o(susp_o), .cfg_error_o(cerr), .pin_mode_o(mode));
  always @(posedge ref_clk_i) begin
    if (sts_oe && !sts_q) rises++;
    sts_q <= sts_oe;
  end
  function automatic logic [15:0] exp_id(input logic [20:0] x);
    if (x == 21'h0) return MAKER;
    if (x == 21'h1) return PART;
    if (x == 21'h5) return burst;
    if (x[20:7] == 14'h1 && x[6:0] <= 7'd8) return pwords[16 * x[3:0] +: 16];
    if (x[15:0] == 16'h2) return {15'h0, bprot[x[20:16]]};
    return 16'h0;
  endfunction
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    chk_data(got[31:16], exp[31:16]);
    chk_data(got[15:0], exp[15:0]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic run_op(input int erase, output int n);
    if (erase != 0) erase_go <= 1'b1;
    else prog_go <= 1'b1;
    tick(1);
    erase_go <= 1'b0;
    prog_go <= 1'b0;
    for (n = 0; n < 5000; ) begin
      tick(1);
      if (busy) n++;
      else if (n > 0) break;
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(8 * 40000);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    tick(20);
    sys_rst_i <= 1'b0;
    bprot <= $random(seed);
    burst <= $random(seed);
    for (i = 0; i < 9; i++) pwords[16 * i +: 16] <= $random(seed);
    tick(1);
    chk_num(mode, 32'h1);
    for (i = 0; i < 60; i++) begin
      a = $random(seed);
      if (i < 9) a = 21'h80 + 21'(i);
      else if (i < 12) a = i == 9 ? 21'h0 : (i == 10 ? 21'h1 : 21'h5);
      else if (i == 12) a = 21'h98;
      else if (i[0]) a[15:0] = 16'h2;
      tick(1);
      rd_addr <= a;
      tick(1);
      #1 chk_data(ident, exp_id(a));
    end
    // ---
    // Each pin mode against one erase and one program
    // ---
    for (c = 0; c < 4; c++) begin
      tick(1);
      HOST.send(16'h00B8, 16'(c));
      tick(3);
      chk_num(mode, 32'h1 << c);
      for (k = 0; k < 2; k++) begin
        nwords <= 5'($random(seed));
        rises = 0;
        run_op(k, len);
        tick(40);
        chk_num(rises, c == 0 ? 1 : (k != 0 ? c[0] : c[1]));
        if (k == 0) chk_num(len, WPC * (nwords + 1));
      end
    end
    HOST.send(16'h00B8, 16'h0007);
    tick(3);
    chk_num({mode, 3'h0, cerr}, 32'h81);
    // Refused configuration and suspend, program first then a long erase
    ecyc <= 32'd400;
    nwords <= 5'h1F;
    for (k = 0; k < 2; k++) begin
      if (k != 0) erase_go <= 1'b1;
      else prog_go <= 1'b1;
      tick(1);
      erase_go <= 1'b0;
      prog_go <= 1'b0;
      tick(5);
      HOST.send(16'h00B8, 16'h0001);
      tick(3);
      chk_num(mode, 32'h8);
      susp <= 1'b1;
      tick(1);
      susp <= 1'b0;
      for (len = 0; len < 40 && !susp_o; len++) tick(1);
      // Four-cycle latency, one to enter pause, one output register, one stale sample
      chk_num(len, 32'd7);
      HOST.send(16'h00B8, 16'h0002);
      tick(3);
      chk_num(mode, 32'h8);
      resm <= 1'b1;
      tick(1);
      resm <= 1'b0;
      for (len = 0; len < 2000 && (busy || susp_o); len++) tick(1);
      chk_num(busy, 32'h0);
    end
    tally_and_finish;
  end
endmodule

//--- sim/host_bus_model.sv
// Host controller model: issues two-write command sequences on the bus
`timescale 1ns/1ps
module host_bus_model (
  input wire logic ref_clk_i, // Clock
  output flash_ident_pkg::bus_wr_t cmd_wr_o // Bus write to the block
);
  initial cmd_wr_o = '0;
  // Call at a clock edge; released data lines drift so stale values are never trusted
  task automatic send(input logic [15:0] d0, input logic [15:0] d1);
    cmd_wr_o <= '{valid: 1'b1, addr: 21'h0, data: d0};
    @(posedge ref_clk_i);
    cmd_wr_o.data <= d1;
    @(posedge ref_clk_i);
    cmd_wr_o.valid <= 1'b0;
    cmd_wr_o.data <= ~d1;
  endtask
endmodule
